//--- rtl/adr_rcv_ctl.sv
// Dual receiver control with option register and host half-word bus
// What this block does
// (R1) Eleven option bits latched on strobe edge
// (R2) Line 4 enables transmit parity in bit 32
// (R3) Line 5 low loops transmitter into receivers
// (R4) Receiver one filters bits 9,10 on lines 7,8
// (R5) Receiver two filters bits 9,10 on lines 10,11
// (R6) Line 12 picks odd or even parity
// (R7) Line 13 picks transmit clock /10 or /80
// (R8) Line 14 picks receive clock /10 or /80
// (R9) Transmit clock output is divided master clock
// (R10) Receivers sample ten times the data rate
// (R11) Words pass the bus as two halves
// (R12) Fixed bit mapping for first and second half
// (R13) Word bit 1 goes first
// (R14) Illegal line level discards the word
// (R15) Received bit 32 shows parity check result
// (R16) Complete matching word sets ready flag low
// (R17) Ready flag holds until both halves read
// (R18) Host reads half with enable and select
// (R19) Receiver one enable has priority on bus
// (R20) New word overwrites unread held word
// (R21) Host resets device with master reset low
// (R22) Bit 32 control enable is active low
// (R23) Control enable picks data or parity bit
// (R24) Halves may be read in either order
// (R25) Reset clears ready flags and partial words
// (R26) Bus driven only while an enable is low
`timescale 1ns/1ps
module adr_rcv_ctl import adr_pkg::*; (
    input wire logic clk_i,                     // Master clock
    input wire logic reset_i,                   // Synchronous reset, high
    input wire logic master_reset_n_i,          // Reset pin, low
    input wire logic [15:0] host_data_lines_i,  // Bus pins in
    output logic [15:0] host_data_lines_o,      // Bus pins out
    output logic host_data_lines_oe_o,          // Bus drive enable
    input wire logic option_strobe_i,           // Option latch strobe
    input wire logic rx_one_output_enable_n_i,  // Read receiver one
    input wire logic rx_two_output_enable_n_i,  // Read receiver two
    input wire logic half_select_i,             // 0 first half, 1 second
    input wire adr_line_t rx_one_line_in_i,     // Receiver one rails
    input wire adr_line_t rx_two_line_in_i,     // Receiver two rails
    input wire adr_line_t tx_serial_out_i,      // Transmitter rails, same clock
    input wire logic tx_first_half_load_n_i,    // Load first half
    input wire logic tx_second_half_load_n_i,   // Load second half
    input wire logic bit32_control_enable_n_i,  // Bit 32 control, low
    output logic rx_one_word_waiting_n_o,       // Receiver one ready, low
    output logic rx_two_word_waiting_n_o,       // Receiver two ready, low
    output logic tx_clk_o,                      // Transmit data clock
    output logic tx_bit_tick_o,                 // Pulse per transmit clock
    output adr_opt_t option_o,                  // Option bits to transmitter
    output logic [31:0] tx_word_o,              // Loaded word, bit 32 resolved
    output logic tx_word_loaded_o               // Pulse: second half taken
);
    adr_pin_t pin_raw, pin_m_q, pin_q, pin_p_q;
    logic rst;
    adr_opt_t opt_q, opt_d;

    // Gather pins; internal pull-up of bit 32 control is a pad matter
    assign pin_raw = '{
        data: host_data_lines_i,
        strobe: option_strobe_i,
        en1_n: rx_one_output_enable_n_i,
        en2_n: rx_two_output_enable_n_i,
        sel: half_select_i,
        rx1: rx_one_line_in_i,
        rx2: rx_two_line_in_i,
        pl1_n: tx_first_half_load_n_i,
        pl2_n: tx_second_half_load_n_i,
        b32_ctl_n: bit32_control_enable_n_i,
        mr_n: master_reset_n_i
    };

    // Two-stage synchroniser plus one history stage for edge finding
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_m_q <= '1;
            pin_q <= '1;
            pin_p_q <= '1;
        end else begin
            pin_m_q <= pin_raw;
            pin_q <= pin_m_q;
            pin_p_q <= pin_q;
        end
    end

    // Either reset source clears the whole receive path
    assign rst = reset_i || !pin_q.mr_n; // [R21] [R25]

    // Option latch takes the data lines on the strobe's rising edge
    always_comb begin
        opt_d = opt_q;
        if (pin_q.strobe && !pin_p_q.strobe) begin
            opt_d = adr_opt_t'(pin_q.data[OPT_LSB +: OPT_W]); // [R1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            opt_q <= adr_opt_t'(OPT_RESET);
        end else begin
            opt_q <= opt_d;
        end
    end

    assign option_o = opt_q;

    // Dividers for the transmit data clock and receive sample strobe
    logic [6:0] tx_div, rx_div;
    logic rx_tick;

    assign tx_div = opt_q.tx_slow ? TX_DIV_SLOW : TX_DIV_FAST; // [R7]
    assign rx_div = opt_q.rx_slow ? RX_DIV_SLOW : RX_DIV_FAST; // [R8] [R10]

    adr_div #(.W(7)) u_tx_div (
        .clk_i(clk_i),
        .reset_i(rst),
        .div_i(tx_div),
        .tick_o(tx_bit_tick_o),
        .clk_o(tx_clk_o) // [R9]
    );

    adr_div #(.W(7)) u_rx_div (
        .clk_i(clk_i),
        .reset_i(rst),
        .div_i(rx_div),
        .tick_o(rx_tick),
        .clk_o()
    );

    // Self test feeds both receivers from the transmitter rails
    adr_line_t rx1_src, rx2_src;

    always_comb begin
        rx1_src = pin_q.rx1;
        rx2_src = pin_q.rx2;
        if (!opt_q.self_test_n) begin
            rx1_src = tx_serial_out_i; // [R3]
            rx2_src = tx_serial_out_i; // [R3]
        end
    end

    logic acc1, acc2;
    logic [31:0] word1, word2;

    adr_rx u_rx1 (
        .clk_i(clk_i),
        .reset_i(rst),
        .tick_i(rx_tick),
        .line_i(rx1_src),
        .filt_i(opt_q.rx1_filt),
        .match_i({opt_q.rx1_b10, opt_q.rx1_b9}), // [R4]
        .accept_o(acc1),
        .word_o(word1)
    );

    adr_rx u_rx2 (
        .clk_i(clk_i),
        .reset_i(rst),
        .tick_i(rx_tick),
        .line_i(rx2_src),
        .filt_i(opt_q.rx2_filt),
        .match_i({opt_q.rx2_b10, opt_q.rx2_b9}), // [R5]
        .accept_o(acc2),
        .word_o(word2)
    );

    // Held words, ready flags and per-half read marks
    logic [31:0] held1_q, held1_d, held2_q, held2_d;
    logic rdy1_q, rdy1_d, rdy2_q, rdy2_d;
    logic [1:0] rd1_q, rd1_d, rd2_q, rd2_d;
    logic sel1_q, sel1_d, sel2_q, sel2_d;
    logic act1, act2, done1, done2;

    // Receiver two only counts as read while receiver one is idle
    assign act1 = !pin_q.en1_n;
    assign act2 = !pin_q.en2_n && pin_q.en1_n; // [R19]
    assign done1 = pin_q.en1_n && !pin_p_q.en1_n;
    assign done2 = pin_q.en2_n && !pin_p_q.en2_n && pin_p_q.en1_n; // Rise of an active read two

    // A half counts as read when its enable rises; new word wins over clear
    always_comb begin
        held1_d = held1_q;
        held2_d = held2_q;
        rdy1_d = rdy1_q;
        rdy2_d = rdy2_q;
        rd1_d = rd1_q;
        rd2_d = rd2_q;
        sel1_d = act1 ? pin_q.sel : sel1_q; // [R18]
        sel2_d = act2 ? pin_q.sel : sel2_q;
        if (done1 && rdy1_q) begin
            rd1_d[sel1_q] = 1'b1; // [R24]
        end
        if (done2 && rdy2_q) begin
            rd2_d[sel2_q] = 1'b1; // [R24]
        end
        if (rd1_d == 2'b11) begin
            rdy1_d = 1'b0; // [R17]
            rd1_d = '0;
        end
        if (rd2_d == 2'b11) begin
            rdy2_d = 1'b0; // [R17]
            rd2_d = '0;
        end
        if (acc1) begin
            held1_d = word1; // [R20]
            rdy1_d = 1'b1; // [R16]
            rd1_d = '0;
        end
        if (acc2) begin
            held2_d = word2; // [R20]
            rdy2_d = 1'b1; // [R16]
            rd2_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            held1_q <= '0;
            held2_q <= '0;
            rdy1_q <= 1'b0; // [R25]
            rdy2_q <= 1'b0; // [R25]
            rd1_q <= '0;
            rd2_q <= '0;
            sel1_q <= 1'b0;
            sel2_q <= 1'b0;
        end else begin
            held1_q <= held1_d;
            held2_q <= held2_d;
            rdy1_q <= rdy1_d;
            rdy2_q <= rdy2_d;
            rd1_q <= rd1_d;
            rd2_q <= rd2_d;
            sel1_q <= sel1_d;
            sel2_q <= sel2_d;
        end
    end

    assign rx_one_word_waiting_n_o = !rdy1_q;
    assign rx_two_word_waiting_n_o = !rdy2_q;

    // Bus output: data and enable both registered from synchronised pins
    logic [15:0] bus_q, bus_d;
    logic oe_q, oe_d;
    logic [31:0] rd_word;

    always_comb begin
        rd_word = act1 ? held1_q : held2_q; // [R19]
        bus_d = pin_q.sel ? adr_half2(rd_word) : adr_half1(rd_word); // [R11] [R12] [R18]
        oe_d = act1 || act2; // [R26]
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            bus_q <= '0;
            oe_q <= 1'b0;
        end else begin
            bus_q <= bus_d;
            oe_q <= oe_d;
        end
    end

    assign host_data_lines_o = bus_q;
    assign host_data_lines_oe_o = oe_q; // [R26]

    // Transmit word assembly from two half loads, first half first
    logic [15:0] h1_q, h1_d;
    logic h1_ok_q, h1_ok_d;
    logic [31:0] txw_q, txw_d, joined;
    logic txl_q, txl_d, par_bit, use_par;

    always_comb begin
        h1_d = h1_q;
        h1_ok_d = h1_ok_q;
        txw_d = txw_q;
        txl_d = 1'b0;
        joined = adr_join(h1_q, pin_q.data); // [R11] [R12] [R13]
        par_bit = opt_q.even_par ? ^joined[30:0] : ~(^joined[30:0]); // [R6] [R2]
        use_par = pin_q.b32_ctl_n || opt_q.par_ins; // [R22] [R23]
        if (!pin_q.pl1_n && pin_p_q.pl1_n) begin
            h1_d = pin_q.data;
            h1_ok_d = 1'b1;
        end else if (!pin_q.pl2_n && pin_p_q.pl2_n && h1_ok_q) begin
            h1_ok_d = 1'b0;
            txw_d = {use_par ? par_bit : joined[31], joined[30:0]}; // [R23]
            txl_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            h1_q <= '0;
            h1_ok_q <= 1'b0;
            txw_q <= '0;
            txl_q <= 1'b0;
        end else begin
            h1_q <= h1_d;
            h1_ok_q <= h1_ok_d;
            txw_q <= txw_d;
            txl_q <= txl_d;
        end
    end

    assign tx_word_o = txw_q;
    assign tx_word_loaded_o = txl_q;
endmodule

//--- rtl/adr_pkg.sv
// Shared constants, carriers and word mapping for the dual avionics receiver
package adr_pkg;
    // Option register: host data lines 14..4 land in bits 10..0
    localparam int OPT_W = 11;
    localparam int OPT_LSB = 4;
    localparam logic [10:0] OPT_RESET = 11'h002; // Self test off after reset
    // Divide factors of the master clock
    localparam logic [6:0] TX_DIV_FAST = 7'h0A; // /10
    localparam logic [6:0] TX_DIV_SLOW = 7'h50; // /80
    localparam logic [6:0] RX_DIV_FAST = 7'h01; // Sample at master rate
    localparam logic [6:0] RX_DIV_SLOW = 7'h08; // Sample at master / 8
    // Receiver sample counts (ten samples per data bit)
    localparam logic [4:0] RX_MIN_LEVEL = 5'h03; // Shortest accepted half bit
    localparam logic [4:0] RX_MAX_LEVEL = 5'h08; // Longest accepted data level
    localparam logic [4:0] RX_GAP_LIMIT = 5'h0F; // Null run that ends a word
    localparam logic [5:0] RX_LAST_BIT = 6'h1F;

    typedef struct packed {
        logic rx_slow;     // Receive data clock /80
        logic tx_slow;     // Transmit data clock /80
        logic even_par;    // Transmit parity sense
        logic rx2_b10;
        logic rx2_b9;
        logic rx2_filt;
        logic rx1_b10;
        logic rx1_b9;
        logic rx1_filt;
        logic self_test_n; // Low loops transmitter into receivers
        logic par_ins;     // Parity insert enable
    } adr_opt_t;

    // Two rails of a three-level line: one/zero both low means null
    typedef struct packed {
        logic one;
        logic zero;
    } adr_line_t;

    // Pin inputs other than clock, reset_i and the transmitter rails, passed through the synchroniser as one vector
    typedef struct packed {
        logic [15:0] data;
        logic strobe;
        logic en1_n;
        logic en2_n;
        logic sel;
        adr_line_t rx1;
        adr_line_t rx2;
        logic pl1_n;
        logic pl2_n;
        logic b32_ctl_n;
        logic mr_n;
    } adr_pin_t;

    // First half: w[k-1] holds word bit k
    function automatic logic [15:0] adr_half1(input logic [31:0] w);
        logic [15:0] h;
        h[15:11] = w[12:8];
        h[10] = w[30];
        h[9] = w[29];
        h[8] = w[31];
        for (int i = 0; i < 8; i++) begin
            h[7 - i] = w[i];
        end
        return h;
    endfunction

    function automatic logic [15:0] adr_half2(input logic [31:0] w);
        return w[28:13];
    endfunction

    // Rebuild a word from its two halves
    function automatic logic [31:0] adr_join(input logic [15:0] h1, input logic [15:0] h2);
        logic [31:0] w;
        w[12:8] = h1[15:11];
        w[30] = h1[10];
        w[29] = h1[9];
        w[31] = h1[8];
        for (int i = 0; i < 8; i++) begin
            w[i] = h1[7 - i];
        end
        w[28:13] = h2;
        return w;
    endfunction
endpackage

//--- rtl/adr_div.sv
// Programmable master clock divider with tick and square wave outputs
`timescale 1ns/1ps
module adr_div import adr_pkg::*; #(
    parameter int W = 7
) (
    input wire logic clk_i,           // Master clock
    input wire logic reset_i,         // Synchronous reset
    input wire logic [W-1:0] div_i,   // Divide factor, at least 1
    output logic tick_o,              // One cycle per period
    output logic clk_o                // High for first half of period
);
    if (W < 2) begin : g_chk
        $error("adr_div needs W of at least 2");
    end

    logic [W-1:0] cnt_q, cnt_d;
    logic clk_q, clk_d;

    // Count wraps at div-1; a changed factor takes effect at once
    always_comb begin
        cnt_d = (cnt_q >= div_i - W'(1)) ? '0 : cnt_q + W'(1);
        clk_d = (cnt_d < (div_i >> 1)) || (div_i == W'(1));
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign tick_o = (cnt_q == '0);
    assign clk_o = clk_q;
endmodule

//--- rtl/adr_rx.sv
// One serial receiver: level checking, bit assembly, parity and label filter
`timescale 1ns/1ps
module adr_rx import adr_pkg::*; (
    input wire logic clk_i,          // Master clock
    input wire logic reset_i,        // Synchronous reset, drops partial word
    input wire logic tick_i,         // Sample strobe, ten per data bit
    input wire adr_line_t line_i,    // Synchronised line rails
    input wire logic filt_i,         // Label filter enable
    input wire logic [1:0] match_i,  // Wanted {bit10, bit9}
    output logic accept_o,           // Pulse: word accepted
    output logic [31:0] word_o       // Last complete word
);
    typedef enum logic [1:0] {LV_NULL, LV_ONE, LV_ZERO} adr_lvl_t;

    adr_lvl_t lvl_q, lvl_d, cur;
    logic [4:0] run_q, run_d;
    logic [5:0] cnt_q, cnt_d;
    logic [31:0] sh_q, sh_d, word_q, word_d, full;
    logic acc_q, acc_d, bad;

    // Classify line; both rails active is outside every legal level
    always_comb begin
        bad = line_i.one && line_i.zero;
        cur = line_i.one ? LV_ONE : (line_i.zero ? LV_ZERO : LV_NULL);
    end

    // Bit assembly, first received bit lands in bit 0
    always_comb begin
        lvl_d = lvl_q;
        run_d = run_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        word_d = word_q;
        acc_d = 1'b0;
        full = sh_q;
        full[cnt_q[4:0]] = (lvl_q == LV_ONE);
        if (tick_i) begin
            if (bad) begin
                cnt_d = '0; // [R14]
                run_d = '0;
                lvl_d = LV_NULL;
            end else if (cur == lvl_q) begin
                run_d = (run_q == 5'h1F) ? run_q : run_q + 5'h01;
                if (lvl_q != LV_NULL && run_q >= RX_MAX_LEVEL) begin
                    cnt_d = '0; // [R14]
                end
                if (lvl_q == LV_NULL && run_q >= RX_GAP_LIMIT) begin
                    cnt_d = '0; // [R14]
                end
            end else begin
                run_d = '0;
                lvl_d = cur;
                case (lvl_q)
                    LV_NULL: begin
                        if (run_q < RX_MIN_LEVEL - 5'h01 && cnt_q != '0) begin
                            cnt_d = '0; // [R14]
                        end
                    end
                    LV_ONE, LV_ZERO: begin
                        if (cur != LV_NULL || run_q < RX_MIN_LEVEL - 5'h01) begin
                            cnt_d = '0; // [R14]
                        end else if (cnt_q == RX_LAST_BIT) begin
                            cnt_d = '0;
                            word_d = {~(^full), full[30:0]}; // [R15]
                            acc_d = !filt_i || (full[9:8] == match_i); // [R16] [R4] [R5]
                        end else begin
                            sh_d = full; // [R13]
                            cnt_d = cnt_q + 6'h01;
                        end
                    end
                    default: begin
                        cnt_d = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lvl_q <= LV_NULL;
            run_q <= '0;
            cnt_q <= '0; // [R25]
            sh_q <= '0;
            word_q <= '0;
            acc_q <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            word_q <= word_d;
            acc_q <= acc_d;
        end
    end

    assign accept_o = acc_q;
    assign word_o = word_q;
endmodule

//--- testbench/adr_rcv_ctl_properties.sv
// Port checker for the dual receiver control block
`timescale 1ns/1ps
module adr_rcv_chk import adr_pkg::*; (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Sync reset
    input wire logic master_reset_n_i, // Reset pin
    input wire logic rx_one_output_enable_n_i, // Read one
    input wire logic rx_two_output_enable_n_i, // Read two
    input wire logic option_strobe_i, // Strobe
    input wire logic host_data_lines_oe_o, // Bus drive
    input wire logic rx_one_word_waiting_n_o, // Flag one
    input wire logic rx_two_word_waiting_n_o, // Flag two
    input wire logic tx_bit_tick_o, // Tx tick
    input wire adr_opt_t option_o // Options
);
    logic [3:0] a1_q, a1_d, a2_q, a2_d, as_q, as_d, am_q, am_d;
    logic [6:0] gap_q, gap_d;
    logic chg_q, chg_d;
    adr_opt_t opt_q;

    // Cycles since an event, saturating so old events never alias
    function automatic logic [3:0] age(input logic ev, input logic [3:0] q);
        return ev ? 4'h0 : (q == 4'hF ? q : q + 4'h1);
    endfunction

    // Ages and tick spacing; an option change voids the next spacing
    always_comb begin
        a1_d = age(!rx_one_output_enable_n_i, a1_q);
        a2_d = age(!rx_two_output_enable_n_i, a2_q);
        as_d = age(option_strobe_i, as_q);
        am_d = age(!master_reset_n_i, am_q);
        gap_d = tx_bit_tick_o ? 7'h00 : gap_q + 7'h01;
        chg_d = (option_o != opt_q) | (am_q < 4'h4) | (chg_q & !tx_bit_tick_o);
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {a1_q, a2_q, as_q, am_q} <= 16'hFFFF;
            gap_q <= 7'h00;
            chg_q <= 1'h1;
        end else begin
            {a1_q, a2_q, as_q, am_q} <= {a1_d, a2_d, as_d, am_d};
            gap_q <= gap_d;
            chg_q <= chg_d;
        end
        opt_q <= option_o;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_oe_cause: assert property (
        host_data_lines_oe_o |-> !$past(rx_one_output_enable_n_i, 3) || !$past(rx_two_output_enable_n_i, 3))
        else $error("bus driven without enable");
    a_oe_answer: assert property (
        (master_reset_n_i && !(rx_one_output_enable_n_i && rx_two_output_enable_n_i)) [*4] |-> host_data_lines_oe_o)
        else $error("enable not answered");
    a_flag1_hold: assert property (
        $rose(rx_one_word_waiting_n_o) |-> a1_q < 4'h8 || am_q < 4'h8)
        else $error("flag one cleared without read");
    a_flag2_hold: assert property (
        $rose(rx_two_word_waiting_n_o) |-> a2_q < 4'h8 || am_q < 4'h8)
        else $error("flag two cleared without read");
    a_option_hold: assert property (
        !$stable(option_o) |-> as_q < 4'h8 || am_q < 4'h8)
        else $error("options changed without strobe");
    a_tick_spacing: assert property (
        tx_bit_tick_o && !chg_q |-> gap_q == (option_o.tx_slow ? 7'h4F : 7'h09))
        else $error("transmit tick spacing wrong");
    a_sync_reset: assert property (disable iff (1'h0)
        reset_i |=> rx_one_word_waiting_n_o && rx_two_word_waiting_n_o && !host_data_lines_oe_o
        && option_o == OPT_RESET)
        else $error("sync reset values wrong");
    a_pin_reset: assert property (
        !master_reset_n_i [*3] |=> rx_one_word_waiting_n_o && rx_two_word_waiting_n_o && !host_data_lines_oe_o)
        else $error("pin reset values wrong");

    c_flag_one: cover property ($fell(rx_one_word_waiting_n_o));
    c_flag_two: cover property ($fell(rx_two_word_waiting_n_o));
    c_bus_read: cover property ($rose(host_data_lines_oe_o));
endmodule

bind adr_rcv_ctl adr_rcv_chk u_adr_rcv_chk (.clk_i, .reset_i, .master_reset_n_i, .rx_one_output_enable_n_i,
    .rx_two_output_enable_n_i, .option_strobe_i, .host_data_lines_oe_o, .rx_one_word_waiting_n_o,
    .rx_two_word_waiting_n_o, .tx_bit_tick_o, .option_o);

//--- testbench/adr_line_src.sv
// Serial line source that sends one word on the two rails
`timescale 1ns/1ps
module adr_line_src import adr_pkg::*; (
    input wire logic clk_i, // Master clock
    output adr_line_t line_o // Rails, null when idle
);
    initial line_o = '0;

    // Data level then null, five samples each; bad marks one illegal bit
    task automatic send(input logic [31:0] w, input int spc, input int bad);
        for (int b = 0; b < 32; b++) begin
            line_o = (b == bad) ? 2'h3 : {w[b], !w[b]};
            repeat (5 * spc) @(negedge clk_i);
            line_o = '0;
            repeat (5 * spc) @(negedge clk_i);
        end
        repeat (40 * spc) @(negedge clk_i); // Word gap
    endtask
endmodule

//--- testbench/test_adr_rcv_ctl.sv
// Self-checking bench for the dual receiver control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_adr_rcv_ctl import adr_pkg::*;;
    localparam logic [31:0] W1 = 32'hA5C3_1E69, W2 = 32'h0F0F_3C01, W3 = 32'h5A3C_96E1;
    localparam logic [10:0] FO [2] = '{11'h00E, 11'h062};
    logic clk = 1'h0, reset = 1'h1, mr_n = 1'h1, strobe = 1'h0, en1_n = 1'h1, en2_n = 1'h1, sel = 1'h0;
    logic pl1_n = 1'h1, pl2_n = 1'h1, dbc_n = 1'h1, oe, ld, tick, w1_n, w2_n, tclk;
    logic [15:0] drv = 16'h0000, dout, bus;
    logic [31:0] txw;
    adr_opt_t opt;
    adr_line_t l1, l2, lt;
    int failures = 0, comparisons = 0;

    always #2.5 clk = ~clk;
    assign bus = oe ? dout : drv; // Wire level of the shared bus

    adr_line_src u_adr_line_src1 (.clk_i(clk), .line_o(l1));
    adr_line_src u_adr_line_src2 (.clk_i(clk), .line_o(l2));
    adr_line_src u_adr_line_src3 (.clk_i(clk), .line_o(lt));
    adr_rcv_ctl u_adr_rcv_ctl (.clk_i(clk), .reset_i(reset), .master_reset_n_i(mr_n), .host_data_lines_i(bus),
        .host_data_lines_o(dout), .host_data_lines_oe_o(oe), .option_strobe_i(strobe),
        .rx_one_output_enable_n_i(en1_n), .rx_two_output_enable_n_i(en2_n), .half_select_i(sel),
        .rx_one_line_in_i(l1), .rx_two_line_in_i(l2), .tx_serial_out_i(lt), .tx_first_half_load_n_i(pl1_n),
        .tx_second_half_load_n_i(pl2_n), .bit32_control_enable_n_i(dbc_n), .rx_one_word_waiting_n_o(w1_n),
        .rx_two_word_waiting_n_o(w2_n), .tx_clk_o(tclk), .tx_bit_tick_o(tick), .option_o(opt),
        .tx_word_o(txw), .tx_word_loaded_o(ld));

    function automatic logic [15:0] h1(input logic [31:0] w);
        return {w[12:8], w[30], w[29], w[31], w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic opt_wr(input logic [10:0] o);
        drv = {1'h0, o, 4'h0};
        cyc(1);
        strobe = 1'h1;
        cyc(3);
        strobe = 1'h0;
        cyc(3);
        `CHK("option", o, opt)
    endtask

    // Reader 1, 2, or 3 for both enables at once
    task automatic rd(input int r, input logic s, input logic [15:0] e);
        sel = s;
        en1_n = (r == 2);
        en2_n = (r == 1);
        for (int n = 0; n < 9 && oe !== 1'h1; n++) cyc(1);
        cyc(1);
        `CHK("bus", e, dout)
        en1_n = 1'h1;
        en2_n = 1'h1;
        for (int n = 0; n < 9 && oe !== 1'h0; n++) cyc(1);
        `CHK("bus idle", 1'h0, oe)
        cyc(3);
    endtask

    // Second half first, since either order must clear the flag
    task automatic rdw(input int r, input logic [31:0] w);
        logic [31:0] x;
        x = {~^w, w[30:0]};
        rd(r, 1'h1, x[28:13]);
        `CHK("flag half", 1'h0, r == 2 ? w2_n : w1_n)
        rd(r, 1'h0, h1(x));
        `CHK("flag clear", 1'h1, r == 2 ? w2_n : w1_n)
    endtask

    task automatic snd(input int r, input logic [31:0] w, input int bad = 99, input int spc = 1);
        if (r == 1) u_adr_line_src1.send(w, spc, bad);
        else if (r == 2) u_adr_line_src2.send(w, spc, bad);
        else u_adr_line_src3.send(w, spc, bad);
    endtask

    // Square wave: high for half of 160 cycles, a whole number of periods at /10 or /80
    task automatic ticks(input int e);
        int c, k;
        c = 0;
        k = 0;
        repeat (160) begin
            cyc(1);
            c += tick;
            k += tclk;
        end
        `CHK("ticks", e, c)
        `CHK("tx clk high", 80, k)
    endtask

    task automatic ld_tx(input logic [31:0] w, input logic [31:0] e);
        drv = h1(w);
        pl1_n = 1'h0;
        cyc(4);
        pl1_n = 1'h1;
        cyc(3);
        drv = w[28:13];
        pl2_n = 1'h0;
        for (int n = 0; n < 9 && ld !== 1'h1; n++) cyc(1);
        `CHK("loaded", 1'h1, ld)
        pl2_n = 1'h1;
        cyc(3);
        `CHK("tx word", e, txw)
    endtask

    task automatic report_and_stop;
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog, several times the expected run
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial begin
        cyc(3);
        reset = 1'h0;
        cyc(3);
        `CHK("reset opt", OPT_RESET, opt)
        `CHK("reset flags", 2'h3, {w1_n, w2_n})
        ticks(16);
        snd(1, W1);
        `CHK("flags", 2'h1, {w1_n, w2_n})
        rdw(3, W1);
        snd(2, W2);
        `CHK("flags", 2'h2, {w1_n, w2_n})
        rdw(2, W2);
        snd(1, W1);
        snd(1, W3);
        rdw(1, W3);
        snd(1, W1, 7);
        `CHK("bad level", 1'h1, w1_n)
        foreach (FO[i]) begin
            opt_wr(FO[i]);
            snd(i + 1, 32'h1234_5000);
            `CHK("no match", 2'h3, {w1_n, w2_n})
            snd(i + 1, 32'h1234_5100);
            rdw(i + 1, 32'h1234_5100);
        end
        opt_wr(11'h000);
        snd(3, W2);
        `CHK("self test", 2'h0, {w1_n, w2_n})
        rdw(1, W2);
        rdw(2, W2);
        opt_wr(11'h602);
        ticks(2);
        snd(2, W1, 99, 8);
        rdw(2, W1);
        opt_wr(11'h002);
        ld_tx(W3, {~^W3[30:0], W3[30:0]});
        dbc_n = 1'h0;
        ld_tx(W3, W3);
        opt_wr(11'h103);
        ld_tx(W3 ^ 32'h8000_0000, {^W3[30:0], W3[30:0]});
        snd(1, W1);
        mr_n = 1'h0;
        cyc(4);
        mr_n = 1'h1;
        cyc(4);
        `CHK("pin reset", 2'h3, {w1_n, w2_n})
        `CHK("pin reset opt", OPT_RESET, opt)
        report_and_stop();
    end
endmodule
